/* File: rtl/rbs_defs.vh */
// Purpose: Constants for the reset and brown-out sequencer
// Assumes: Included by rtl/rbs_reset_seq.v only
// Notes: Register offsets are word indices on the plain register port
`ifndef RBS_DEFS_VH
`define RBS_DEFS_VH

// Register offsets
`define RBS_ADDR_W 2
`define RBS_OFS_BOR_CTRL 2'h0
`define RBS_OFS_CAUSE 2'h1
`define RBS_OFS_STATUS 2'h2

// Brown-out control fields
`define RBS_BC_SW_EN 7
`define RBS_BC_BG_FORCE 6
`define RBS_BC_READY 0
`define RBS_BC_SW_EN_RST 1'b1
`define RBS_BC_BG_FORCE_RST 1'b0

// Reset-cause fields
`define RBS_RC_STK_OVER 7
`define RBS_RC_STK_UNDER 6
`define RBS_RC_WDT 4
`define RBS_RC_EXT 3
`define RBS_RC_RI 2
`define RBS_RC_POR 1
`define RBS_RC_BOR 0
`define RBS_RC_WMASK 8'hdf
`define RBS_RC_POR_VAL 8'h1c

// Status fields
`define RBS_ST_TIMEOUT 4
`define RBS_ST_POWERDOWN 3

// Brown-out mode encodings
`define RBS_MODE_OFF 2'h0
`define RBS_MODE_SW 2'h1
`define RBS_MODE_NOSLEEP 2'h2
`define RBS_MODE_ON 2'h3

// Timing
`define RBS_CLK_KHZ 10000
`define RBS_POWERUP_DELAY_TIMER_US 64000
`define RBS_POWERUP_DELAY_TIMER_CYCLES (`RBS_POWERUP_DELAY_TIMER_US * `RBS_CLK_KHZ / 1000)
`define RBS_START_CYCLES 10
`define RBS_PIN_FILT_CYCLES 3

// Vectors
`define RBS_RESET_VEC 16'h0000
`define RBS_IRQ_VEC 16'h0004

`endif

/* File: rtl/rbs_reset_seq.v */
// Purpose: Reset source combiner, power-up delay, brown-out control and reset-cause flags
// Assumes: All inputs but rst_b synchronous to clk_sys; analog detectors supply digital levels
// Notes: The core runs only while core_reset_b is high
`timescale 1ns/1ps
`include "rbs_defs.vh"

// Function
// - Mode 01: software bit switches brown-out
// - Protection starts when ready; sleep-independent
// - Software enable bit 7, resets to one
// - Bandgap force bit 6, modes 10/01
// - Ready bit 0 read-only; bits 5-1 zero
// - Low-power detector resets, updates brown-out flag
// - Low-power detector enabled by config bit
// - Pin reset enabled by enable or LOW_VOLTAGE_PROG_CFG
// - Low pin holds reset, glitch filtered, pull-up
// - Pin is never driven low
// - Disabled pin is input, software pull-up
// - Watchdog timeout resets, updates timeout/powerdown
// - Reset instruction resets, clears its flag
// - Stack fault resets only when enabled
// - Programming-mode exit acts as power-on
// - Start waits for timer and pin release
// - Timer independent; ten cycles after late pin
// - Power-on loads flags 00 110x, status 11
// - Pin reset clears pin flag; sleep case
// - Watchdog reset versus watchdog wake-up
// - Interrupt wake continues, optional vector request
// - Stack resets set their flag only
// - Power-up timer nominal 64 ms, enable low
// - Hardware clears cause flags except stack flags, which it sets; firmware sets
module rbs_reset_seq #(
	parameter POWERUP_DELAY_TIMER_CYCLES = `RBS_POWERUP_DELAY_TIMER_CYCLES,
	parameter START_CYCLES = `RBS_START_CYCLES,
	parameter FILT_CYCLES = `RBS_PIN_FILT_CYCLES
) (
	input wire clk_sys,
	input wire rst_b,
	input wire [`RBS_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [1:0] brownout_mode_cfg,
	input wire powerup_delay_en_n,
	input wire ext_reset_pin_en,
	input wire low_voltage_prog_cfg,
	input wire lowpower_brownout_en,
	input wire stack_fault_reset_en,
	input wire brownout_circuit_ready,
	input wire brownout_vdd_low,
	input wire lowpower_vdd_low,
	input wire prog_mode,
	input wire ext_reset_pin_in,
	input wire sw_pullup_en,
	input wire sleep_active,
	input wire sleep_enter,
	input wire watchdog_clear_instr,
	input wire watchdog_timeout,
	input wire reset_instr,
	input wire stack_over,
	input wire stack_under,
	input wire irq_wake,
	input wire global_irq_enable,
	output wire ext_reset_pin_out,
	output wire ext_reset_pin_oe,
	output wire ext_reset_pin_pullup,
	output reg gpio_pin_in,
	output wire brownout_enable,
	output wire bandgap_force,
	output wire core_reset_b,
	output reg wake_resume,
	output reg wake_irq_vector,
	output wire timeout_flag,
	output wire powerdown_flag,
	output wire [7:0] reset_cause
);

	localparam [2:0] ST_HOLD = 3'h0;
	localparam [2:0] ST_POWERUP_DELAY_TIMER = 3'h1;
	localparam [2:0] ST_PIN = 3'h2;
	localparam [2:0] ST_START = 3'h3;
	localparam [2:0] ST_RUN = 3'h4;
	localparam [19:0] POWERUP_DELAY_TIMER_LAST = POWERUP_DELAY_TIMER_CYCLES - 1;
	localparam [3:0] START_LAST = START_CYCLES - 1;
	localparam [3:0] FILT_LAST = FILT_CYCLES - 1;

	reg rst_meta;
	reg rst_sync;
	reg [2:0] state;
	reg [2:0] next_state;
	reg power_type;
	reg pin_waited;
	reg [19:0] powerup_delay_timer_cnt;
	reg [3:0] start_cnt;
	reg [3:0] filt_cnt;
	reg pin_low_f;
	reg pin_low_d;
	reg bor_trip_d;
	reg lp_trip_d;
	reg prog_d;
	reg sw_brownout_en;
	reg bandgap_force_on;
	reg [7:0] cause;
	reg to_flag;
	reg pd_flag;

	// Two-flop release keeps the asynchronous reset edge off the state logic
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Brown-out enable per mode; software bit counts only in mode 01
	assign brownout_enable = (brownout_mode_cfg == `RBS_MODE_ON) ||
		((brownout_mode_cfg == `RBS_MODE_NOSLEEP) && !sleep_active) ||
		((brownout_mode_cfg == `RBS_MODE_SW) && sw_brownout_en);
	// Force bit is inert in modes 11 and 00
	assign bandgap_force = bandgap_force_on &&
		((brownout_mode_cfg == `RBS_MODE_NOSLEEP) || (brownout_mode_cfg == `RBS_MODE_SW));

	wire bor_ready = brownout_enable && brownout_circuit_ready;
	// Protection only once ready, and sleep is not a term here in mode 01
	wire bor_trip = bor_ready && brownout_vdd_low;
	wire lp_trip = lowpower_brownout_en && lowpower_vdd_low;
	wire pin_en = ext_reset_pin_en || low_voltage_prog_cfg;
	wire pin_hold = pin_en && pin_low_f;
	wire stack_rst = stack_fault_reset_en && (stack_over || stack_under);
	wire wdt_rst = watchdog_timeout && !sleep_active;
	wire prog_exit = prog_d && !prog_mode;
	wire bor_evt = bor_trip && !bor_trip_d;
	wire lp_evt = lp_trip && !lp_trip_d;
	wire pin_evt = pin_hold && !pin_low_d;
	wire power_evt = bor_evt || lp_evt || prog_exit || prog_mode;
	// Every source except the pin; the pin is tracked apart so the timer runs regardless
	wire src_nopin = bor_trip || lp_trip || prog_mode || prog_exit || wdt_rst ||
		reset_instr || stack_rst;
	// Modes 11 and 10 wait for a ready detector and good supply; 01 and 00 do not
	wire bor_wait = ((brownout_mode_cfg == `RBS_MODE_ON) ||
		(brownout_mode_cfg == `RBS_MODE_NOSLEEP)) && (!bor_ready || brownout_vdd_low);

	// Glitch filter: the pin must read low for FILT_CYCLES samples in a row
	always @(posedge clk_sys or negedge rst_sync) begin
		if (!rst_sync) begin
			filt_cnt <= 4'h0;
			pin_low_f <= 1'b0;
			pin_low_d <= 1'b0;
			bor_trip_d <= 1'b0;
			lp_trip_d <= 1'b0;
			prog_d <= 1'b0;
			gpio_pin_in <= 1'b0;
		end else begin
			if (ext_reset_pin_in) begin
				filt_cnt <= 4'h0;
				pin_low_f <= 1'b0;
			end else if (filt_cnt == FILT_LAST) begin
				pin_low_f <= 1'b1;
			end else begin
				filt_cnt <= filt_cnt + 4'h1;
			end
			pin_low_d <= pin_hold;
			bor_trip_d <= bor_trip;
			lp_trip_d <= lp_trip;
			prog_d <= prog_mode;
			gpio_pin_in <= pin_en ? 1'b0 : ext_reset_pin_in;
		end
	end

	// Input only: a reset never pulls the pin
	assign ext_reset_pin_out = 1'b0;
	assign ext_reset_pin_oe = 1'b0;
	assign ext_reset_pin_pullup = pin_en ? 1'b1 : sw_pullup_en;

	always @* begin
		next_state = state;
		case (state)
			ST_HOLD: begin
				if (!src_nopin)
					next_state = (power_type && !powerup_delay_en_n) ? ST_POWERUP_DELAY_TIMER : ST_PIN;
			end
			ST_POWERUP_DELAY_TIMER: begin
				if (powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_LAST)
					next_state = ST_PIN;
			end
			ST_PIN: begin
				if (!pin_hold && !bor_wait)
					next_state = pin_waited ? ST_START : ST_RUN;
			end
			ST_START: begin
				if (pin_hold)
					next_state = ST_PIN;
				else if (start_cnt == START_LAST)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (pin_hold)
					next_state = ST_PIN;
			end
			default: next_state = ST_HOLD;
		endcase
		// Any live source other than the pin overrides the sequence
		if (src_nopin)
			next_state = ST_HOLD;
	end

	always @(posedge clk_sys or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= ST_HOLD;
			power_type <= 1'b1;
			pin_waited <= 1'b0;
			powerup_delay_timer_cnt <= 20'h0;
			start_cnt <= 4'h0;
		end else begin
			state <= next_state;
			if (power_evt)
				power_type <= 1'b1;
			else if (next_state == ST_RUN)
				power_type <= 1'b0;
			// Timer counts whatever the pin does
			if (state == ST_POWERUP_DELAY_TIMER)
				powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 20'h1;
			else
				powerup_delay_timer_cnt <= 20'h0;
			if (state == ST_PIN && pin_hold)
				pin_waited <= 1'b1;
			else if (next_state == ST_RUN)
				pin_waited <= 1'b0;
			if (state == ST_START)
				start_cnt <= start_cnt + 4'h1;
			else
				start_cnt <= 4'h0;
		end
	end

	// Release leaves the core at the reset vector
	assign core_reset_b = (state == ST_RUN);

	// Wake-ups from sleep continue at the next instruction
	always @(posedge clk_sys or negedge rst_sync) begin
		if (!rst_sync) begin
			wake_resume <= 1'b0;
			wake_irq_vector <= 1'b0;
		end else begin
			wake_resume <= sleep_active && core_reset_b && (watchdog_timeout || irq_wake);
			wake_irq_vector <= sleep_active && core_reset_b && !watchdog_timeout &&
				irq_wake && global_irq_enable;
		end
	end

	// Registers and flags; hardware updates come after the software write so they win
	always @(posedge clk_sys or negedge rst_sync) begin
		if (!rst_sync) begin
			sw_brownout_en <= `RBS_BC_SW_EN_RST;
			bandgap_force_on <= `RBS_BC_BG_FORCE_RST;
			cause <= `RBS_RC_POR_VAL;
			to_flag <= 1'b1;
			pd_flag <= 1'b1;
		end else begin
			if (reg_wr && reg_addr == `RBS_OFS_BOR_CTRL) begin
				sw_brownout_en <= reg_wdata[`RBS_BC_SW_EN];
				bandgap_force_on <= reg_wdata[`RBS_BC_BG_FORCE];
			end
			if (reg_wr && reg_addr == `RBS_OFS_CAUSE)
				cause <= reg_wdata & `RBS_RC_WMASK;
			if (watchdog_clear_instr) begin
				to_flag <= 1'b1;
				pd_flag <= 1'b1;
			end
			if (sleep_enter) begin
				to_flag <= 1'b1;
				pd_flag <= 1'b0;
			end
			if (watchdog_timeout) begin
				to_flag <= 1'b0;
				if (sleep_active)
					pd_flag <= 1'b0;
				else
					cause[`RBS_RC_WDT] <= 1'b0;
			end
			if (irq_wake && sleep_active && !watchdog_timeout) begin
				to_flag <= 1'b1;
				pd_flag <= 1'b0;
			end
			if (pin_evt) begin
				cause[`RBS_RC_EXT] <= 1'b0;
				if (sleep_active) begin
					to_flag <= 1'b1;
					pd_flag <= 1'b0;
				end
			end
			if (reset_instr)
				cause[`RBS_RC_RI] <= 1'b0;
			if (stack_fault_reset_en && stack_over)
				cause[`RBS_RC_STK_OVER] <= 1'b1;
			if (stack_fault_reset_en && stack_under)
				cause[`RBS_RC_STK_UNDER] <= 1'b1;
			if (bor_evt || lp_evt) begin
				// Brown-out pattern 00 11u0, status 1 1
				cause[`RBS_RC_STK_OVER] <= 1'b0;
				cause[`RBS_RC_STK_UNDER] <= 1'b0;
				cause[`RBS_RC_EXT] <= 1'b1;
				cause[`RBS_RC_RI] <= 1'b1;
				cause[`RBS_RC_BOR] <= 1'b0;
				to_flag <= 1'b1;
				pd_flag <= 1'b1;
				sw_brownout_en <= `RBS_BC_SW_EN_RST;
				bandgap_force_on <= `RBS_BC_BG_FORCE_RST;
			end
			if (prog_exit) begin
				cause <= `RBS_RC_POR_VAL;
				to_flag <= 1'b1;
				pd_flag <= 1'b1;
				sw_brownout_en <= `RBS_BC_SW_EN_RST;
				bandgap_force_on <= `RBS_BC_BG_FORCE_RST;
			end
		end
	end

	assign timeout_flag = to_flag;
	assign powerdown_flag = pd_flag;
	assign reset_cause = cause;

	// Read data stand one cycle after the strobe, zero otherwise
	always @(posedge clk_sys or negedge rst_sync) begin
		if (!rst_sync) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`RBS_OFS_BOR_CTRL: reg_rdata <= {sw_brownout_en, bandgap_force_on, 5'h00,
					bor_ready};
				`RBS_OFS_CAUSE: reg_rdata <= cause;
				`RBS_OFS_STATUS: reg_rdata <= {3'h0, to_flag, pd_flag, 3'h0};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

/* File: verif/rbs_reset_seq_chk.sv */
// Purpose: Port assertions for rbs_reset_seq
// Assumes: Bound to the design top, one clock
// Notes: Quiet while rst_b is low
`timescale 1ns/1ps
module rbs_reset_seq_chk (
	input wire clk_sys,
	input wire rst_b,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire [1:0] brownout_mode_cfg,
	input wire ext_reset_pin_en,
	input wire low_voltage_prog_cfg,
	input wire lowpower_brownout_en,
	input wire lowpower_vdd_low,
	input wire stack_fault_reset_en,
	input wire sw_pullup_en,
	input wire sleep_active,
	input wire watchdog_timeout,
	input wire reset_instr,
	input wire stack_under,
	input wire global_irq_enable,
	input wire ext_reset_pin_oe,
	input wire ext_reset_pin_pullup,
	input wire brownout_enable,
	input wire bandgap_force,
	input wire core_reset_b,
	input wire wake_resume,
	input wire wake_irq_vector,
	input wire timeout_flag,
	input wire [7:0] reset_cause
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_pin_no_drive: assert property (!ext_reset_pin_oe)
		else $error("reset pin driven");
	a_pullup_select: assert property (ext_reset_pin_pullup ==
		(ext_reset_pin_en | low_voltage_prog_cfg | sw_pullup_en)) else $error("pull-up wrong");
	a_sw_bor_off: assert property (reg_wr && reg_addr == 2'h0 && !reg_wdata[7] &&
		brownout_mode_cfg == 2'h1 |=> !brownout_enable) else $error("bor still on");
	a_bg_inert: assert property (brownout_mode_cfg[0] == brownout_mode_cfg[1]
		|-> !bandgap_force) else $error("bandgap forced");
	a_instr_reset: assert property (reset_instr && core_reset_b
		|=> !core_reset_b && !reset_cause[2]) else $error("instr reset missed");
	a_stack_reset: assert property (stack_under && stack_fault_reset_en && core_reset_b
		|=> !core_reset_b && reset_cause[6]) else $error("stack reset missed");
	a_wdt_reset: assert property (watchdog_timeout && !sleep_active && core_reset_b
		|=> !core_reset_b && !timeout_flag && !reset_cause[4]) else $error("wdt reset missed");
	a_ctrl_zero_bits: assert property (reg_rd && reg_addr == 2'h0
		|=> reg_rdata[5:1] == 5'h0) else $error("unused bits set");
	a_irq_vector: assert property (wake_irq_vector
		|-> wake_resume && $past(global_irq_enable)) else $error("vector without wake");
	a_lp_hold: assert property (lowpower_brownout_en && lowpower_vdd_low
		|=> !core_reset_b && !reset_cause[0]) else $error("low-power bor missed");
	c_instr: cover property (reset_instr && core_reset_b);
	c_wake_irq: cover property (wake_irq_vector);
	c_lp: cover property (lowpower_brownout_en && lowpower_vdd_low);
endmodule

/* File: verif/rbs_reset_seq_tb.sv */
// Purpose: Directed bench for rbs_reset_seq
// Assumes: Power-up delay shortened to 50 cycles
// Notes: Pulse inputs share one vector
`timescale 1ns/1ps
module rbs_reset_seq_tb;
	localparam int RI = 0, SO = 1, SU = 2, WT = 3, WC = 4, SE = 5, IW = 6;
	logic clk_sys = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, prog_mode = 1'h0;
	logic [1:0] reg_addr = 2'h0, brownout_mode_cfg = 2'h1;
	logic [7:0] reg_wdata = 8'h0, reg_rdata, reset_cause;
	logic [6:0] pv = 7'h0;
	logic powerup_delay_en_n = 1'h0, ext_reset_pin_en = 1'h1, low_voltage_prog_cfg = 1'h0;
	logic lowpower_brownout_en = 1'h1, stack_fault_reset_en = 1'h0, brownout_circuit_ready = 1'h1;
	logic brownout_vdd_low = 1'h0, lowpower_vdd_low = 1'h0, ext_reset_pin_in = 1'h1;
	logic sw_pullup_en = 1'h0, sleep_active = 1'h0, global_irq_enable = 1'h1;
	logic ext_reset_pin_out, ext_reset_pin_oe, ext_reset_pin_pullup, gpio_pin_in, brownout_enable;
	logic bandgap_force, core_reset_b, wake_resume, wake_irq_vector, timeout_flag, powerdown_flag;
	wire reset_instr = pv[RI], stack_over = pv[SO], stack_under = pv[SU];
	wire watchdog_timeout = pv[WT], watchdog_clear_instr = pv[WC];
	wire sleep_enter = pv[SE], irq_wake = pv[IW];
	int fails = 0, cmp_count = 0, n = 0;
	always #50 clk_sys = ~clk_sys;
	rbs_reset_seq #(.POWERUP_DELAY_TIMER_CYCLES(50)) i_rbs_reset_seq (.*);
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic clk(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(string nm, logic [1:0] a, logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		clk(1);
		reg_rd <= 1'h0;
		chk(nm, e, reg_rdata);
	endtask
	task automatic pulse(int s);
		@(posedge clk_sys);
		pv <= 7'h1 << s;
		@(posedge clk_sys);
		pv <= 7'h0;
	endtask
	// Waits for core run (w=0) or wake pulse (w=1)
	task automatic wait_hi(bit w);
		#1;
		for (n = 0; (w ? wake_resume : core_reset_b) !== 1'h1 && n < 300; n++)
			clk(1);
		chk("wait", 8'h1, {7'h0, w ? wake_resume : core_reset_b});
	endtask
	task automatic t_power();
		wait_hi(1'h0);
		chk("powerup_delay_timer", 8'h1, {7'h0, n >= 50 && n <= 64});
		rd("cause_por", 2'h1, 8'h1c);
		rd("status_por", 2'h2, 8'h18);
		rd("ctrl_rst", 2'h0, 8'h81);
		wr(2'h0, 8'h3f);
		rd("ctrl_off", 2'h0, 8'h00);
		chk("pin_out", 8'h0, {6'h0, ext_reset_pin_out, ext_reset_pin_oe});
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys);
			brownout_mode_cfg <= 2'(m);
			wr(2'h0, 8'hc0);
			clk(0);
			chk("bg_force", {7'h0, m == 1 || m == 2}, {7'h0, bandgap_force});
		end
		wr(2'h3, 8'hff);
		rd("unmapped", 2'h3, 8'h00);
		wr(2'h2, 8'h00);
		rd("status_ro", 2'h2, 8'h18);
		$display("test power and registers done");
	endtask
	task automatic t_src();
		@(posedge clk_sys);
		brownout_mode_cfg <= 2'h1;
		wr(2'h1, 8'h1f);
		pulse(RI);
		wait_hi(1'h0);
		rd("cause_ri", 2'h1, 8'h1b);
		stack_fault_reset_en <= 1'h1;
		pulse(SU);
		wait_hi(1'h0);
		rd("cause_su", 2'h1, 8'h5b);
		stack_fault_reset_en <= 1'h0;
		pulse(SO);
		clk(3);
		chk("stack_off", 8'h1, {7'h0, core_reset_b});
		pulse(WT);
		wait_hi(1'h0);
		rd("status_wdt", 2'h2, 8'h08);
		rd("cause_wdt", 2'h1, 8'h4b);
		pulse(WC);
		pulse(SE);
		sleep_active <= 1'h1;
		pulse(WT);
		wait_hi(1'h1);
		rd("status_wake", 2'h2, 8'h00);
		chk("pd_out", 8'h0, {6'h0, timeout_flag, powerdown_flag});
		pulse(SE);
		pulse(IW);
		wait_hi(1'h1);
		chk("irq_vec", 8'h1, {7'h0, wake_irq_vector});
		rd("status_irq", 2'h2, 8'h10);
		$display("test reset sources done");
	endtask
	task automatic t_pin();
		pulse(WC);
		ext_reset_pin_in <= 1'h0;
		clk(6);
		chk("pin_hold", 8'h0, {7'h0, core_reset_b});
		@(posedge clk_sys);
		ext_reset_pin_in <= 1'h1;
		sleep_active <= 1'h0;
		wait_hi(1'h0);
		rd("status_pin", 2'h2, 8'h10);
		rd("cause_pin", 2'h1, 8'h43);
		ext_reset_pin_in <= 1'h0;
		@(posedge clk_sys);
		ext_reset_pin_in <= 1'h1;
		clk(4);
		chk("glitch", 8'h1, {7'h0, core_reset_b});
		@(posedge clk_sys);
		ext_reset_pin_en <= 1'h0;
		sw_pullup_en <= 1'h1;
		ext_reset_pin_in <= 1'h0;
		clk(5);
		chk("gpio", 8'h1, {6'h0, gpio_pin_in, core_reset_b});
		@(posedge clk_sys);
		ext_reset_pin_en <= 1'h1;
		prog_mode <= 1'h1;
		@(posedge clk_sys);
		prog_mode <= 1'h0;
		clk(80);
		chk("late_hold", 8'h0, {7'h0, core_reset_b});
		ext_reset_pin_in <= 1'h1;
		wait_hi(1'h0);
		chk("start", 8'h1, {7'h0, n >= 10 && n <= 16});
		rd("status_prog", 2'h2, 8'h18);
		wr(2'h1, 8'h1f);
		lowpower_brownout_en <= 1'h0;
		lowpower_vdd_low <= 1'h1;
		clk(4);
		chk("lp_off", 8'h1, {7'h0, core_reset_b});
		lowpower_brownout_en <= 1'h1;
		@(posedge clk_sys);
		lowpower_vdd_low <= 1'h0;
		wait_hi(1'h0);
		rd("cause_lp", 2'h1, 8'h1e);
		wr(2'h1, 8'h1f);
		@(posedge clk_sys);
		brownout_vdd_low <= 1'h1;
		@(posedge clk_sys);
		brownout_vdd_low <= 1'h0;
		wait_hi(1'h0);
		chk("bor_powerup_delay_timer", 8'h1, {7'h0, n >= 50 && n <= 64});
		rd("cause_bor", 2'h1, 8'h1e);
		rd("status_bor", 2'h2, 8'h18);
		$display("test pin and low-power done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'h1;
		t_power();
		t_src();
		t_pin();
		conclude();
	end
	// Whole run is under 500 cycles
	initial begin
		#800000;
		fails++;
		conclude();
	end
endmodule
bind rbs_reset_seq rbs_reset_seq_chk i_chk (.*);
